// [verilog/register_file_address_map.sv]
// register file, program and data space decoder for an 8-bit core
// assumes the core drives one request per enabled cycle, same clock
//
// Functional notes
// - requests in all three spaces (register file, program, data) are answered; only register file reads return data.
// - the register file space is 4096 bytes of working and control bytes.
// - the top 256 bytes up to the highest address hold control registers.
// - source operands are read and destination operands are written.
// - reading a reserved control location returns undefined data.
// - on-chip RAM always starts at register file address zero.
// - implemented RAM is between 256 bytes and 1 KB, per variant.
// - reads between RAM top and control base return undefined data.
// - writes between RAM top and control base are dropped.
// - the program space seen by the core spans 64 KB.
// - 1 KB to 8 KB of flash sits in the program space, per variant.
module register_file_address_map
   import addr_space_pkg::*;
#(
   parameter int unsigned    RAM_BYTES   = RAM_SIZE,
   parameter int unsigned    FLASH_BYTES = FLASH_SIZE,
   parameter logic [255:0]   CTRL_IMPL   = {256{1'b1}}
) (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic         clkEn,
   input  wire core_req_t    req,
   input  wire logic [7:0]   ctrlIn,
   output core_rsp_t         rsp,
   output logic [7:0]        ctrlAddr,
   output logic [7:0]        ctrlWdata,
   output logic              ctrlWr,
   output logic              ctrlRd
);
   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   // working registers live here; control bytes belong to peripherals
   logic [7:0] ram [RAM_MAX];
   region_t    region;
   core_rsp_t  rsp_d;
   core_rsp_t  rsp_q;
   logic [7:0] ctrlAddr_q;
   logic [7:0] ctrlWdata_q;
   logic       ctrlWr_q;
   logic       ctrlRd_q;

   reg_region_decode #(
      .RAM_BYTES (RAM_BYTES),
      .CTRL_LO   (CTRL_BASE)
   ) u_decode (
      .addr      (req.addr[11:0]),
      .ctrlImpl  (CTRL_IMPL),
      .region    (region)
   );

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire isReg   = (req.space == SPACE_REG);
   wire isProg  = (req.space == SPACE_PROG);
   wire isData  = (req.space == SPACE_DATA);
   wire regOk   = isReg && (req.addr[15:12] == 4'h0);
   wire ramHit  = regOk && (region == CLS_RAM);
   wire ctrlHit = regOk && (region == CLS_CTRL);
   wire rsvdHit = regOk && (region == CLS_RSVD);
   // full 16-bit program space; flash occupies the bottom of it
   wire flashHit = isProg && ({16'h0, req.addr} < FLASH_BYTES);
   wire ramWr   = clkEn && req.wr && ramHit;
   // reserved writes still reach the bus; effect is the peripheral's
   wire ctrlWrHit = req.wr && (ctrlHit || rsvdHit);
   wire [RAM_AW-1:0] ramIx = req.addr[RAM_AW-1:0];
   wire [7:0]  rdSel = ramHit ? ram[ramIx]
                     : UNDEF_DATA;

   always_comb begin
      rsp_d         = '0;
      rsp_d.valid   = req.rd || req.wr;
      rsp_d.defined = req.rd && (ramHit || ctrlHit || flashHit);
      rsp_d.region  = isReg ? region : CLS_UNIMP;
      rsp_d.progHit = flashHit;
      rsp_d.rdata   = req.rd ? rdSel : UNDEF_DATA;
   end

   // -----------------------------------------------------------------
   // ram array
   // -----------------------------------------------------------------
   // no reset on the array: contents are undefined after power-up
   always_ff @(posedge mclk) begin
      if (ramWr) begin
         ram[ramIx] <= req.wdata;
      end
   end

   // -----------------------------------------------------------------
   // response and control port registers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rsp_q       <= '0;
         ctrlAddr_q  <= CTRL_RESET;
         ctrlWdata_q <= CTRL_RESET;
         ctrlWr_q    <= 1'b0;
         ctrlRd_q    <= 1'b0;
      end else if (clkEn) begin
         rsp_q       <= rsp_d;
         ctrlAddr_q  <= req.addr[7:0];
         ctrlWdata_q <= req.wdata;
         ctrlWr_q    <= ctrlWrHit;
         ctrlRd_q    <= req.rd && ctrlHit;
      end
   end

   // control reads are answered one cycle later from the peripheral
   wire [7:0] rdOut = rsp_q.rdata;
   always_comb begin
      rsp = rsp_q;
      if (ctrlRd_q) begin
         rsp.rdata = ctrlIn;
      end else begin
         rsp.rdata = rdOut;
      end
   end

   assign ctrlAddr  = ctrlAddr_q;
   assign ctrlWdata = ctrlWdata_q;
   assign ctrlWr    = ctrlWr_q;
   assign ctrlRd    = ctrlRd_q;
endmodule

// [verilog/addr_space_pkg.sv]
// shared constants and carrier types for the address-space decoder
// assumes a single clock domain owned by the processor core
package addr_space_pkg;
   // -----------------------------------------------------------------
   // register file space
   // -----------------------------------------------------------------
   localparam int unsigned REG_ADDR_W    = 12;
   localparam int unsigned REG_SPACE     = 4096;
   localparam int unsigned CTRL_SIZE     = 256;
   localparam logic [11:0] CTRL_BASE     = 12'hF00;
   localparam logic [11:0] RAM_BASE      = 12'h000;
   localparam int unsigned RAM_MIN       = 256;
   localparam int unsigned RAM_MAX       = 1024;
   localparam int unsigned RAM_SIZE      = 1024;
   localparam int unsigned RAM_AW        = 10;
   localparam logic [7:0]  UNDEF_DATA    = 8'hFF;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   // -----------------------------------------------------------------
   // program and data memory spaces
   // -----------------------------------------------------------------
   localparam int unsigned PROG_ADDR_W   = 16;
   localparam int unsigned FLASH_MIN     = 1024;
   localparam int unsigned FLASH_MAX     = 8192;
   localparam int unsigned FLASH_SIZE    = 8192;
   localparam int unsigned DATA_ADDR_W   = 16;

   typedef enum logic [1:0] {
      SPACE_REG, SPACE_PROG, SPACE_DATA
   } space_t;

   typedef enum logic [1:0] {
      CLS_RAM, CLS_CTRL, CLS_RSVD, CLS_UNIMP
   } region_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      space_t      space;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } core_req_t;

   typedef struct packed {
      logic        valid;
      logic        defined;
      region_t     region;
      logic        progHit;
      logic [7:0]  rdata;
   } core_rsp_t;
endpackage

// [verilog/reg_region_decode.sv]
// combinational classifier for one register file address
// assumes the address is already stable in the core's clock domain
module reg_region_decode
   import addr_space_pkg::*;
#(
   parameter int unsigned RAM_BYTES = RAM_SIZE,
   parameter logic [11:0] CTRL_LO   = CTRL_BASE
) (
   input  wire logic [11:0]         addr,
   input  wire logic [CTRL_SIZE-1:0] ctrlImpl,
   output region_t                  region
);
   // -----------------------------------------------------------------
   // region compare
   // -----------------------------------------------------------------
   wire        inRam  = ({20'h0, addr} < RAM_BYTES);
   wire        inCtrl = (addr >= CTRL_LO);
   wire [7:0]  ctrlIx = addr[7:0];
   wire        impl   = ctrlImpl[ctrlIx];

   assign region = inCtrl ? (impl ? CLS_CTRL : CLS_RSVD)
                 : inRam  ? CLS_RAM : CLS_UNIMP;
endmodule

// [test/reg_map_checker_assertions.sv]
// port checks for the register file address map
// assumes default RAM size and all control bytes implemented
module reg_map_checker
   import addr_space_pkg::*;
(
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic       clkEn,
   input wire core_req_t  req,
   input wire logic [7:0] ctrlIn,
   input wire core_rsp_t  rsp,
   input wire logic [7:0] ctrlAddr,
   input wire logic [7:0] ctrlWdata,
   input wire logic       ctrlWr,
   input wire logic       ctrlRd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // properties
   // ----------------
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   wire regAcc = clkEn && req.space == SPACE_REG;
   wire ctl = regAcc && req.addr[15:8] == 8'h0F;
   // gap above 1 KB RAM and below control base
   wire gap = regAcc && req.addr[15:10] != 6'h00 && req.addr[15:8] < 8'h0F;
   wire ramRd  = regAcc && req.rd && req.addr[15:10] == 6'h00;
   wire progRd = clkEn && req.rd && req.space == SPACE_PROG;
   AST_VALID: assert property (
      clkEn && (req.rd || req.wr) |=> rsp.valid)
      else $error("no answer");
   AST_IDLE: assert property (
      clkEn && !req.rd && !req.wr |=> !rsp.valid)
      else $error("answer without request");
   AST_CTRL_RD: assert property (
      ctl && req.rd |=> ctrlRd && ctrlAddr == $past(req.addr[7:0]))
      else $error("control read missed");
   AST_CTRL_WR: assert property (
      ctl && req.wr |=> ctrlWr && ctrlWdata == $past(req.wdata))
      else $error("control write missed");
   AST_NO_WR: assert property (
      clkEn && !(ctl && req.wr) |=> !ctrlWr)
      else $error("stray control write");
   AST_RAM: assert property (
      ramRd |=> rsp.region == CLS_RAM && rsp.defined)
      else $error("RAM not at bottom");
   AST_UNIMP: assert property (
      gap && req.rd |=> rsp.rdata == UNDEF_DATA && !rsp.defined)
      else $error("gap read defined");
   AST_CTRL_DATA: assert property (
      ctrlRd |-> rsp.rdata == ctrlIn)
      else $error("control data lost");
   AST_PROG: assert property (
      progRd |=> rsp.progHit == ($past(req.addr) < 16'h2000))
      else $error("flash hit wrong");
   COV_RD: cover property (ctrlRd);
   COV_WR: cover property (ctrlWr);
   COV_GAP: cover property (rsp.valid && rsp.region == CLS_UNIMP);
endmodule

bind register_file_address_map reg_map_checker u_reg_map_checker (
   .mclk(mclk), .reset(reset), .clkEn(clkEn), .req(req), .ctrlIn(ctrlIn),
   .rsp(rsp), .ctrlAddr(ctrlAddr), .ctrlWdata(ctrlWdata), .ctrlWr(ctrlWr),
   .ctrlRd(ctrlRd));

// [test/ctrl_periph_model.sv]
// peripheral side answering control register reads
// assumes reads are qualified by the one-cycle read pulse
module ctrl_periph_model (
   input wire logic       mclk,
   input wire logic       ctrlRd,
   input wire logic [7:0] ctrlAddr,
   output logic [7:0]     ctrlIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_q = 8'h00;
   // outside a read, drive the inverse of last cycle's value, so never show stale data
   assign ctrlIn = ctrlRd ? (ctrlAddr ^ 8'hA5) : ~last_q;
   always @(posedge mclk) last_q <= ctrlIn;
endmodule

// [test/tb_top.sv]
// self-checking bench for the register file address map
// assumes the bound checker and the peripheral model
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import addr_space_pkg::*;
   logic       mclk, reset, clkEn, ctrlWr, ctrlRd;
   logic [7:0] ctrlIn, ctrlAddr, ctrlWdata;
   core_req_t  req;
   core_rsp_t  rsp;
   int         n_fail = 0, samples_checked = 0, cycles = 0;
   register_file_address_map u_register_file_address_map (.mclk(mclk),
      .reset(reset), .clkEn(clkEn), .req(req), .ctrlIn(ctrlIn), .rsp(rsp),
      .ctrlAddr(ctrlAddr), .ctrlWdata(ctrlWdata), .ctrlWr(ctrlWr),
      .ctrlRd(ctrlRd));
   ctrl_periph_model u_ctrl_periph_model (.mclk(mclk), .ctrlRd(ctrlRd),
      .ctrlAddr(ctrlAddr), .ctrlIn(ctrlIn));
   // ----------------
   // tasks
   // ----------------
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one request, answer sampled after the next edge settles
   task automatic op(input logic r, input logic w, input space_t s,
                     input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{r, w, s, a, d};
      @(posedge mclk);
      req <= '0;
      #1;
   endtask
   task automatic ram_test;
      op(0, 1, SPACE_REG, 16'h0000, 8'h3C);
      op(0, 1, SPACE_REG, 16'h03FF, 8'hC3);
      op(1, 0, SPACE_REG, 16'h0000, 8'h00);
      chk(rsp.rdata, 8'h3C);
      chk(8'(rsp.region), 8'(CLS_RAM));
      chk(8'(rsp.valid), 8'h01);
      op(1, 0, SPACE_REG, 16'h03FF, 8'h00);
      chk(rsp.rdata, 8'hC3);
   endtask
   task automatic gap_test;
      op(0, 1, SPACE_REG, 16'h0400, 8'h77);
      chk(8'(ctrlWr), 8'h00);
      op(1, 0, SPACE_REG, 16'h0400, 8'h00);
      chk(rsp.rdata, UNDEF_DATA);
      chk(8'(rsp.defined), 8'h00);
      chk(8'(rsp.region), 8'(CLS_UNIMP));
      op(1, 0, SPACE_REG, 16'h0000, 8'h00);
      chk(rsp.rdata, 8'h3C);
      // frozen cycle: a RAM write must not land
      @(posedge mclk);
      clkEn <= 1'b0;
      req <= '{1'b0, 1'b1, SPACE_REG, 16'h0000, 8'h99};
      @(posedge mclk);
      req <= '0;
      clkEn <= 1'b1;
      op(1, 0, SPACE_REG, 16'h0000, 8'h00);
      chk(rsp.rdata, 8'h3C);
   endtask
   task automatic ctrl_test;
      op(1, 0, SPACE_REG, 16'h0F10, 8'h00);
      chk(rsp.rdata, 8'hB5);
      op(0, 1, SPACE_REG, 16'h0FFF, 8'h5E);
      chk(8'(ctrlWr), 8'h01);
      chk(ctrlAddr, 8'hFF);
      chk(ctrlWdata, 8'h5E);
   endtask
   task automatic prog_test;
      op(1, 0, SPACE_PROG, 16'h1FFF, 8'h00);
      chk(8'(rsp.progHit), 8'h01);
      op(1, 0, SPACE_PROG, 16'h2000, 8'h00);
      chk(8'(rsp.progHit), 8'h00);
      op(1, 0, SPACE_DATA, 16'h0000, 8'h00);
      chk(rsp.rdata, UNDEF_DATA);
      chk(8'(rsp.progHit), 8'h00);
   endtask
   // ----------------
   // run
   // ----------------
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_fail++;
         give_verdict;
      end
   end
   initial begin
      reset = 1'b1;
      clkEn = 1'b1;
      req = '0;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      ram_test;
      gap_test;
      ctrl_test;
      prog_test;
      give_verdict;
   end
endmodule
